//--- verification/psm_mem_model.sv
// Purpose: behavioural sync SRAM / FIFO on the far side of the port
// Assumes: memClk is the output clock that the active space uses
// Notes: outside its read window the bus toggles, so a sample one output-clock cycle late never matches

`timescale 1ns/1ps

module psm_mem_model
  import psm_pkg::*;
(
  input wire logic memClk,
  input wire logic [LAT_W-1:0] rdLat,
  input wire logic [LAT_W-1:0] wrLat,
  input wire logic [NUM_SPACES-1:0] chipSelectN,
  input wire logic [BE_W-1:0] byteEnableN,
  input wire logic [ADDR_W-1:0] extAddress,
  input wire logic [DATA_W-1:0] extDataOut,
  input wire logic extDataOeN,
  input wire logic strobePinN,
  input wire logic syncWriteEnableN,
  input wire logic syncOutputEnableN,
  output logic [DATA_W-1:0] memData,
  output int wrErr
);
  logic [DATA_W-1:0] mem [16];
  logic [3:0] rA;
  logic [3:0] wA;
  logic [BE_W-1:0] wBe;
  int rCnt;
  int wCnt;
  bit rPend;
  bit wPend;

  initial begin
    memData = 16'h0;
    wrErr = 0;
    rPend = 0;
    wPend = 0;
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'h0;
    end
  end

  // mid-period view: pins launched after one rise are settled before the next
  always @(negedge memClk) begin
    memData = ~memData;
    if (rPend) rCnt++;
    if (wPend) wCnt++;
    if (!(&chipSelectN) && !strobePinN) begin
      if (syncWriteEnableN) begin
        rPend = 1;
        rCnt = 0;
        rA = extAddress[3:0];
      end else begin
        wPend = 1;
        wCnt = 0;
        wA = extAddress[3:0];
        wBe = ~byteEnableN;
      end
    end
    if (rPend && rCnt == rdLat) begin
      // read word loaded onto the toggling bus only under output enable, so a missing enable shows as bad data
      if (syncOutputEnableN === 1'b0) memData = mem[rA];
      rPend = 0;
    end
    if (wPend && wCnt == wrLat) begin
      wPend = 0;
      if (extDataOeN !== 1'b0) wrErr++;
      for (int b = 0; b < BE_W; b++) begin
        if (wBe[b]) mem[wA][b*8 +: 8] = extDataOut[b*8 +: 8];
      end
    end
  end
endmodule

//--- verification/tb_top.sv
// Purpose: self-checking bench for the synchronous memory port
// Assumes: both output clocks free-running, unrelated to clk_sys
// Notes: expected read words queued at acceptance, popped when rdValid shows

`timescale 1ns/1ps

module tb_top
  import psm_pkg::*;
;
  logic clk_sys, nrst, ctrlWrite, reqValid, reqReady, reqWrite, rdValid;
  logic [SPACE_W-1:0] ctrlSpace, reqSpace;
  logic [CTRL_W-1:0] ctrlData;
  logic [ADDR_W-1:0] reqAddr, extAddress;
  logic [BE_W-1:0] reqBe, byteEnableN;
  logic [DATA_W-1:0] reqData, rdData, extDataOut, extDataIn, memData;
  logic priClk, secClk, clkSel, extDataOeN, strobePinN, syncOutputEnableN;
  logic syncWriteEnableN, syncActive, sawFull;
  logic [NUM_SPACES-1:0] chipSelectN;
  logic [LAT_W-1:0] rdLat, wrLat;
  logic [DATA_W-1:0] shadow [16];
  logic [DATA_W-1:0] expQ [$];
  int wrErr, fail_count, n_compared, seed, spSel;

  assign extDataIn = extDataOeN ? memData : extDataOut;

  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    priClk = 0;
    forever #62.5 priClk = ~priClk;
  end
  initial begin
    secClk = 0;
    #17;
    forever #87.5 secClk = ~secClk;
  end

  psm_sync_port u_dut (.clk_sys(clk_sys), .nrst(nrst), .ctrlWrite(ctrlWrite),
    .ctrlSpace(ctrlSpace), .ctrlData(ctrlData), .reqValid(reqValid), .reqReady(reqReady),
    .reqWrite(reqWrite), .reqSpace(reqSpace), .reqAddr(reqAddr), .reqBe(reqBe),
    .reqData(reqData), .rdValid(rdValid), .rdData(rdData), .primaryOutClock(priClk),
    .secondaryOutClock(secClk), .chipSelectN(chipSelectN), .byteEnableN(byteEnableN),
    .extAddress(extAddress), .extDataOut(extDataOut), .extDataOeN(extDataOeN),
    .extDataIn(extDataIn), .strobePinN(strobePinN), .syncOutputEnableN(syncOutputEnableN),
    .syncWriteEnableN(syncWriteEnableN), .syncActive(syncActive));

  psm_mem_model u_mem (.memClk(clkSel ? secClk : priClk), .rdLat(rdLat), .wrLat(wrLat),
    .chipSelectN(chipSelectN), .byteEnableN(byteEnableN), .extAddress(extAddress),
    .extDataOut(extDataOut), .extDataOeN(extDataOeN), .strobePinN(strobePinN),
    .syncWriteEnableN(syncWriteEnableN), .syncOutputEnableN(syncOutputEnableN),
    .memData(memData), .wrErr(wrErr));

  // -------------------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------------------
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cmpVal(input string nm, input logic [DATA_W-1:0] exp,
                        input logic [DATA_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic setCfg(input int sp, input int rl, input int wl, input bit ext,
                        input bit ren, input bit cs);
    @(negedge clk_sys);
    ctrlWrite = 1;
    ctrlSpace = SPACE_W'(sp);
    ctrlData = {cs, ren, ext, LAT_W'(wl), LAT_W'(rl)};
    @(negedge clk_sys);
    ctrlWrite = 0;
    rdLat = LAT_W'(rl);
    wrLat = LAT_W'(wl);
    clkSel = cs;
    spSel = sp;
  endtask

  // valid held until an edge where reqReady is high
  task automatic sendReq(input bit wr, input int sp, input int a, input logic [BE_W-1:0] be,
                         input logic [DATA_W-1:0] d);
    int n;
    @(negedge clk_sys);
    reqValid = 1;
    reqWrite = wr;
    reqSpace = SPACE_W'(sp);
    reqAddr = ADDR_W'(a);
    reqBe = be;
    reqData = d;
    n = 0;
    while (reqReady !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 2000) begin
      cmpVal("reqReady wait", 1, 0);
      end_sim();
    end
    @(posedge clk_sys);
    if (wr) begin
      for (int b = 0; b < BE_W; b++) begin
        if (be[b]) shadow[a][b*8 +: 8] = d[b*8 +: 8];
      end
    end else begin
      expQ.push_back(shadow[a]);
    end
  endtask

  task automatic drain();
    int n;
    @(negedge clk_sys);
    reqValid = 0;
    n = 0;
    while ((expQ.size() != 0 || syncActive !== 1'b0) && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 20000) begin
      cmpVal("drain wait", 1, 0);
      end_sim();
    end
  endtask

  always @(negedge clk_sys) begin
    if (reqReady === 1'b0) sawFull = 1;
    // only the addressed space may see its select low
    if (chipSelectN !== '1 && chipSelectN !== ~(CS_ONE << spSel)) begin
      cmpVal("chipSelectN", 16'(~(CS_ONE << spSel)), 16'(chipSelectN));
    end
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) cmpVal("rdValid extra", 0, 1);
      else cmpVal("rdData", expQ.pop_front(), rdData);
    end
  end

  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    seed = 56;
    spSel = 0;
    {nrst, ctrlWrite, ctrlSpace, ctrlData, reqValid, reqWrite, reqSpace} = '0;
    {reqAddr, reqBe, reqData, rdLat, wrLat, clkSel, sawFull} = '0;
    fail_count = 0;
    n_compared = 0;
    for (int i = 0; i < 16; i++) shadow[i] = 16'h0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1;
    cmpVal("chipSelectN reset", 16'h000f, 16'(chipSelectN));
    cmpVal("syncActive reset", 16'h0, 16'(syncActive));
    // every latency, extend, strobe mode and clock choice, one space each
    for (int k = 0; k < 8; k++) begin
      setCfg(k % 4, (k + 1) % 4, k % 4, k[2], k[1], k[0]);
      sendReq(1, k % 4, k, BE_W'(k % 3 + 1), 16'($random(seed)));
      sendReq(0, k % 4, k, 2'h3, 16'h0);
      drain();
      cmpVal("write latency", 16'h0, 16'(wrErr));
      $display("test config %0d done", k);
    end
    // slow clock so the queue fills while accesses run strobe-mode-1 back to back
    setCfg(0, 3, 2, 1'b0, 1'b1, 1'b1);
    sawFull = 0;
    for (int i = 0; i < 24; i++) begin
      sendReq(i < 12, 0, i % 12, 2'h3, 16'($random(seed)));
    end
    drain();
    cmpVal("queue full", 16'h1, 16'(sawFull));
    cmpVal("write latency burst", 16'h0, 16'(wrErr));
    $display("test burst done");
    end_sim();
  end
endmodule

//--- verilog/psm_fifo.sv
// Purpose: request queue between the user side and the pin sequencer
// Assumes: DEPTH is a power of two
// Notes: inReady is registered so the user sees a flop

`timescale 1ns/1ps

module psm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_q;
  logic [PTR_W-1:0] rdPtr_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic push;
  logic pop;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign count_d = count_q + CNT_W'(push) - CNT_W'(pop);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      inReady <= 1'b1;
    end else begin
      if (push) begin
        wrPtr_q <= PTR_W'(wrPtr_q + 1'b1);
      end
      if (pop) begin
        rdPtr_q <= PTR_W'(rdPtr_q + 1'b1);
      end
      count_q <= count_d;
      inReady <= (count_d != CNT_W'(DEPTH));
    end
  end
endmodule

//--- verilog/psm_pkg.sv
// Purpose: shared constants and types of the programmable synchronous memory port
// Assumes: four chip-select spaces, 16-bit data, 20-bit word address
// Notes: secondary control word layout is local to this port

package psm_pkg;
  localparam int NUM_SPACES = 4;
  localparam int SPACE_W = 2;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 20;
  localparam int BE_W = 2;
  localparam int LAT_W = 2;
  // -------------------------------------------------------------------------
  // secondary control word per space
  // -------------------------------------------------------------------------
  localparam int CTRL_W = 7;
  localparam int CTRL_RL_LSB = 0;
  localparam int CTRL_WL_LSB = 2;
  localparam int CTRL_CSEXT_BIT = 4;
  localparam int CTRL_REN_BIT = 5;
  localparam int CTRL_CLKSEL_BIT = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
  // -------------------------------------------------------------------------
  // request queue and tick counting
  // -------------------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int REQ_W = 1 + SPACE_W + ADDR_W + BE_W + DATA_W;
  localparam int TICK_W = 3;
  localparam logic [TICK_W-1:0] TICK_ONE = 3'h1;
  localparam logic [TICK_W-1:0] TICK_MAX = 3'h7;
  localparam logic [NUM_SPACES-1:0] CS_ONE = 4'h1;

  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_WAIT  = 4'h2,
    S_LAT   = 4'h4,
    S_DESEL = 4'h8
  } psm_state_t;
endpackage

//--- verilog/psm_sync_port.sv
// Purpose: synchronous burst/ZBT SRAM and sync FIFO pin sequencer
// Assumes: both output clocks are free-running and slower than clk_sys / 2
// Notes: one word per access; pins change only after a selected clock edge
//
// What this block does
// - read latency per space is zero to three output-clock cycles
// - write latency per space is zero to three output-clock cycles
// - extension clear: chip select released after the command edge
// - extension set: chip select held while sync output enable is low
// - strobe mode clear: strobe is address strobe, deselect cycle follows
// - strobe mode set: strobe is FIFO read enable, no deselect cycle
// - each space picks primary or secondary output clock for timing
// - settings held in one secondary control register per space
// - strobe, output enable and write enable take synchronous roles here
// - read data captured on selected output clock rising edge
// - all memory-side pins update from selected output clock rising edge

`timescale 1ns/1ps

module psm_sync_port
  import psm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ctrlWrite,
  input wire logic [SPACE_W-1:0] ctrlSpace,
  input wire logic [CTRL_W-1:0] ctrlData,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [SPACE_W-1:0] reqSpace,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [BE_W-1:0] reqBe,
  input wire logic [DATA_W-1:0] reqData,
  output logic rdValid,
  output logic [DATA_W-1:0] rdData,
  input wire logic primaryOutClock,
  input wire logic secondaryOutClock,
  output logic [NUM_SPACES-1:0] chipSelectN,
  output logic [BE_W-1:0] byteEnableN,
  output logic [ADDR_W-1:0] extAddress,
  output logic [DATA_W-1:0] extDataOut,
  output logic extDataOeN,
  input wire logic [DATA_W-1:0] extDataIn,
  output logic strobePinN,
  output logic syncOutputEnableN,
  output logic syncWriteEnableN,
  output logic syncActive
);
  // -------------------------------------------------------------------------
  // secondary control registers
  // -------------------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q [NUM_SPACES];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= '{default: CTRL_RESET};
    end else if (ctrlWrite) begin
      ctrl_q[ctrlSpace] <= ctrlData;
    end
  end

  // -------------------------------------------------------------------------
  // pin input synchronisers and clock edge detect
  // -------------------------------------------------------------------------
  logic pri1_q, pri2_q, pri3_q;
  logic sec1_q, sec2_q, sec3_q;
  logic [DATA_W-1:0] din1_q, din2_q;
  logic priRise, secRise, tick;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {pri1_q, pri2_q, pri3_q} <= '0;
      {sec1_q, sec2_q, sec3_q} <= '0;
      {din1_q, din2_q} <= '0;
    end else begin
      {pri1_q, pri2_q, pri3_q} <= {primaryOutClock, pri1_q, pri2_q};
      {sec1_q, sec2_q, sec3_q} <= {secondaryOutClock, sec1_q, sec2_q};
      // data and clocks share the same two-stage delay, so a tick samples
      // the bus as it stood at that output-clock edge
      din1_q <= extDataIn;
      din2_q <= din1_q;
    end
  end

  assign priRise = pri2_q && !pri3_q;
  assign secRise = sec2_q && !sec3_q;

  // -------------------------------------------------------------------------
  // request queue and current access
  // -------------------------------------------------------------------------
  psm_state_t state_q;
  logic [REQ_W-1:0] fifoOut;
  logic fifoValid, fifoPop, finish;
  logic curWr_q, curCsExt_q, curRen_q, curClkSel_q;
  logic [SPACE_W-1:0] curSpace_q;
  logic [ADDR_W-1:0] curAddr_q;
  logic [BE_W-1:0] curBe_q;
  logic [DATA_W-1:0] curData_q;
  logic [LAT_W-1:0] curRl_q, curWl_q;
  logic [TICK_W-1:0] cnt_q;
  logic [CTRL_W-1:0] selCtrl;

  psm_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .inValid(reqValid),
    .inReady(reqReady),
    .inData({reqWrite, reqSpace, reqAddr, reqBe, reqData}),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoOut)
  );

  assign fifoPop = fifoValid && (state_q == S_IDLE);
  assign selCtrl = ctrl_q[fifoOut[REQ_W-2 -: SPACE_W]];
  assign tick = curClkSel_q ? secRise : priRise;
  // read ends on its capture edge, write on the edge after data was driven
  assign finish = (state_q == S_LAT) && tick &&
                  (curWr_q ? !extDataOeN : (cnt_q == TICK_W'(curRl_q)));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {curWr_q, curCsExt_q, curRen_q, curClkSel_q} <= '0;
      {curSpace_q, curAddr_q, curBe_q, curData_q} <= '0;
      {curRl_q, curWl_q} <= '0;
    end else if (fifoPop) begin
      {curWr_q, curSpace_q, curAddr_q, curBe_q, curData_q} <= fifoOut;
      // settings latched per access so a rewrite cannot upset one in flight
      curRl_q <= selCtrl[CTRL_RL_LSB +: LAT_W];
      curWl_q <= selCtrl[CTRL_WL_LSB +: LAT_W];
      curCsExt_q <= selCtrl[CTRL_CSEXT_BIT];
      curRen_q <= selCtrl[CTRL_REN_BIT];
      curClkSel_q <= selCtrl[CTRL_CLKSEL_BIT];
    end
  end

  // -------------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: state_q <= fifoValid ? S_WAIT : S_IDLE;
        S_WAIT: state_q <= tick ? S_LAT : S_WAIT;
        S_LAT: state_q <= !finish ? S_LAT : (curRen_q ? S_IDLE : S_DESEL);
        S_DESEL: state_q <= tick ? S_IDLE : S_DESEL;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (tick && state_q == S_WAIT) begin
      cnt_q <= '0;
    end else if (tick && state_q == S_LAT) begin
      cnt_q <= cnt_q + TICK_ONE;
    end
  end

  // -------------------------------------------------------------------------
  // pins, all launched on a selected clock edge
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      chipSelectN <= '1;
      byteEnableN <= '1;
      extAddress <= '0;
      extDataOut <= '0;
      {extDataOeN, strobePinN, syncOutputEnableN, syncWriteEnableN} <= '1;
    end else if (tick && state_q == S_WAIT) begin
      chipSelectN <= ~(CS_ONE << curSpace_q);
      byteEnableN <= ~curBe_q;
      extAddress <= curAddr_q;
      extDataOut <= curData_q;
      strobePinN <= 1'b0;
      syncOutputEnableN <= curWr_q;
      syncWriteEnableN <= ~curWr_q;
      extDataOeN <= !(curWr_q && curWl_q == '0);
    end else if (tick && state_q == S_LAT) begin
      strobePinN <= 1'b1;
      syncWriteEnableN <= 1'b1;
      if (curWr_q || !curCsExt_q) begin
        chipSelectN <= '1;
      end
      if (finish) begin
        chipSelectN <= '1;
        byteEnableN <= '1;
        syncOutputEnableN <= 1'b1;
        extDataOeN <= 1'b1;
      end else if (curWr_q && (cnt_q + TICK_ONE) == TICK_W'(curWl_q)) begin
        extDataOeN <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdValid <= 1'b0;
      rdData <= '0;
    end else begin
      rdValid <= finish && !curWr_q;
      if (finish && !curWr_q) begin
        rdData <= din2_q;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      syncActive <= 1'b0;
    end else if (tick && state_q == S_WAIT) begin
      syncActive <= 1'b1;
    end else if ((finish && curRen_q) || (tick && state_q == S_DESEL)) begin
      syncActive <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  logic [TICK_W-1:0] hTicks_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hTicks_q <= '0;
    end else if (tick && state_q == S_WAIT) begin
      hTicks_q <= '0;
    end else if (tick && hTicks_q != TICK_MAX) begin
      hTicks_q <= hTicks_q + TICK_ONE;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_rd_latency;
    rdValid |-> (hTicks_q == TICK_W'(curRl_q) + TICK_ONE);
  endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("read latency wrong");

  property p_wr_latency;
    $fell(extDataOeN) |-> (hTicks_q == TICK_W'(curWl_q)) && curWr_q;
  endproperty
  a_wr_latency: assert property (p_wr_latency) else $error("write latency wrong");

  property p_cs_release;
    (state_q inside {S_LAT, S_DESEL} && !curCsExt_q && hTicks_q != '0) |-> &chipSelectN;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("chip select held");

  property p_cs_extend;
    (curCsExt_q && !syncOutputEnableN) |-> !(&chipSelectN);
  endproperty
  a_cs_extend: assert property (p_cs_extend) else $error("chip select dropped");

  property p_deselect;
    (finish && !curRen_q) |=> (state_q == S_DESEL) && strobePinN && (&chipSelectN);
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect missing");

  property p_no_deselect;
    (finish && curRen_q) |=> (state_q == S_IDLE);
  endproperty
  a_no_deselect: assert property (p_no_deselect) else $error("deselect inserted");

  property p_clock_sel;
    (state_q == S_WAIT && curClkSel_q && !secRise) |=> $stable(chipSelectN);
  endproperty
  a_clock_sel: assert property (p_clock_sel) else $error("wrong clock used");

  property p_ctrl_hold;
    ctrlWrite |=> ctrl_q[$past(ctrlSpace)] == $past(ctrlData);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control not held");

  property p_sync_role;
    !(&chipSelectN) |-> syncActive;
  endproperty
  a_sync_role: assert property (p_sync_role) else $error("pins not in sync role");

  property p_capture;
    rdValid |-> $past(tick) && (rdData == $past(din2_q));
  endproperty
  a_capture: assert property (p_capture) else $error("capture off edge");

  property p_pins_on_edge;
    ($changed(extAddress) || $changed(chipSelectN) || $changed(strobePinN)) |-> $past(tick);
  endproperty
  a_pins_on_edge: assert property (p_pins_on_edge) else $error("pin moved off edge");
endmodule
